// ### core/sec_defs.svh
// shared constants of the serial EEPROM command engine
`ifndef SEC_DEFS_SVH
`define SEC_DEFS_SVH
`define SEC_OP_CTL 2'h0
`define SEC_OP_WR 2'h1
`define SEC_OP_RD 2'h2
`define SEC_OP_ER 2'h3
`define SEC_SUB_LOCK 2'h0
`define SEC_SUB_WRA 2'h1
`define SEC_SUB_ERA 2'h2
`define SEC_SUB_WEN 2'h3
`define SEC_AB8 5'h0B
`define SEC_AB16 5'h0A
`define SEC_DB8 5'h08
`define SEC_DB16 5'h10
`define SEC_HDR 5'h03
`define SEC_WORDS 512
`define SEC_ERASED 16'hFFFF
`define SEC_CLK_NS 5
`define SEC_T_WP_NS 5000000
`define SEC_T_WP_CYC (`SEC_T_WP_NS / `SEC_CLK_NS)
`define SEC_T_CS_NS 200
`define SEC_T_CS_CYC ((`SEC_T_CS_NS + `SEC_CLK_NS - 1) / `SEC_CLK_NS)
`define SEC_SK_HALF 50
`define SEC_SETTLE 8'h08
`define SEC_FIFO_DEPTH 16
`endif

// ### core/sec_pkg.sv
// types shared by both ends of the serial EEPROM link
package sec_pkg;
    typedef enum logic [1:0] {
        D_IDLE = 2'b00,
        D_SHIFT = 2'b01,
        D_READ = 2'b10,
        D_ARMED = 2'b11
    } sec_dst_t;
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LO = 3'b001,
        H_HI = 3'b010,
        H_RLO = 3'b011,
        H_RHI = 3'b100,
        H_END = 3'b101,
        H_POLL = 3'b110
    } sec_hst_t;
    typedef enum logic [2:0] {
        C_READ = 3'b000,
        C_WRITE = 3'b001,
        C_ERASE = 3'b010,
        C_ERASE_WHOLE_ARRAY = 3'b011,
        C_WRITE_WHOLE_ARRAY = 3'b100,
        C_WRITE_ENABLE = 3'b101,
        C_PROGRAM_LOCK = 3'b110
    } sec_cmd_t;
endpackage : sec_pkg

// ### core/sec_if.sv
// three-wire serial link between host controller and EEPROM
`timescale 1ns/10ps
`default_nettype none
interface sec_if;
    logic cs;
    logic sk;
    logic di;
    logic dout;
    logic dout_oe_n;
    logic dout_pin;
    // undriven data out line is pulled high
    assign dout_pin = dout_oe_n ? 1'b1 : dout;
    modport dev (input cs, input sk, input di, output dout,
        output dout_oe_n);
    modport host (output cs, output sk, output di, input dout_pin);
endinterface : sec_if
`default_nettype wire

// ### core/sec_dev.sv
// EEPROM end: instruction decoder, array and self-timed programming
//
// Overview of operation
// - byte mode: 11-bit address, 8 data, 14/22 clocks
// - host gives exactly the required clock count
// - opcode 00, address 10 erases whole array
// - opcode 00, address 01 writes whole array
// - don't-care address bits are ignored
// - write whole array fills every location
// - host drops select after write whole array
// - select low 200 ns, then status shown
// - host drops select after single erase
// - select falling edge starts self-timed cycle
// - status reads 0 busy, 1 ready
// - erase whole array sets all ones
// - no instruction accepted during reset
// - reset release clears state, enters standby
// - reset reassertion abandons current activity
// - standby only when no write is running
// - host waits for ready before next instruction
// - write-enable latch cleared out of reset
// - writes and erases need write-enable latch
// - read outputs dummy 0, then data MSB first
// - read streams upward, wrapping, until select low
`include "sec_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module sec_dev #(
    parameter int T_WP_CYC = `SEC_T_WP_CYC
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic WIDTH_SELECT,
    output logic READY,
    output logic WRITE_ENABLED,
    sec_if.dev LINK
);
    import sec_pkg::*;

    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] sk_s;
        logic [1:0] di_s;
        logic [1:0] org_s;
        logic csp;
        logic skp;
        sec_dst_t st;
        logic [28:0] sh;
        logic [4:0] cnt;
        logic [1:0] op;
        logic [1:0] sub;
        logic [9:0] adr;
        logic [15:0] dat;
        logic wel;
        logic stat;
        logic rdy;
        logic dout;
        logic oe_n;
        logic [31:0] bcnt;
        logic [15:0] rsh;
        logic [4:0] rcnt;
    } sec_dctl_t;
    typedef struct packed {
        sec_dctl_t c;
        logic [`SEC_WORDS-1:0][15:0] mem;
    } sec_dstate_t;

    sec_dstate_t q;
    sec_dstate_t d;
    logic rise;
    logic csfall;
    logic cs_hi;
    logic x8;
    logic [4:0] ab;
    logic [4:0] db;
    logic [4:0] n;
    logic [28:0] nsh;
    logic [15:0] pat;
    logic [15:0] val;
    logic [9:0] an;

    // byte mode puts the byte in the upper half for MSB-first shifting
    function automatic logic [15:0] fetch(input logic b,
        input logic [9:0] a);
        logic [15:0] w;
        w = b ? q.mem[a[9:1]] : q.mem[a[8:0]];
        return b ? {(a[0] ? w[7:0] : w[15:8]), 8'h00} : w;
    endfunction : fetch

    always_comb
    begin
        d = q;
        rise = q.c.sk_s[1] & ~q.c.skp;
        csfall = ~q.c.cs_s[1] & q.c.csp;
        cs_hi = q.c.cs_s[1];
        x8 = ~q.c.org_s[1];
        ab = x8 ? `SEC_AB8 : `SEC_AB16;
        db = x8 ? `SEC_DB8 : `SEC_DB16;
        nsh = {q.c.sh[27:0], q.c.di_s[1]};
        n = q.c.cnt + 5'h01;
        pat = x8 ? {q.c.dat[7:0], q.c.dat[7:0]} : q.c.dat;
        val = (q.c.op == `SEC_OP_ER) ? `SEC_ERASED : pat;
        an = x8 ? q.c.adr + 10'h001 : {1'b0, q.c.adr[8:0] + 9'h001};
        d.c.cs_s = {q.c.cs_s[0], LINK.cs};
        d.c.sk_s = {q.c.sk_s[0], LINK.sk};
        d.c.di_s = {q.c.di_s[0], LINK.di};
        d.c.org_s = {q.c.org_s[0], WIDTH_SELECT};
        d.c.csp = q.c.cs_s[1];
        d.c.skp = q.c.sk_s[1];
        if (q.c.bcnt != 32'h0)
        begin
            d.c.bcnt = q.c.bcnt - 32'h1;
        end
        case (q.c.st)
            D_IDLE:
            begin
                // a start bit is only taken once programming is over
                if (rise && cs_hi && q.c.di_s[1] && q.c.bcnt == 32'h0)
                begin
                    d.c.st = D_SHIFT;
                    d.c.cnt = 5'h00;
                    d.c.sh = '0;
                    d.c.stat = 1'b0;
                end
            end
            D_SHIFT:
            begin
                if (!cs_hi)
                begin
                    d.c.st = D_IDLE;
                end
                else if (rise)
                begin
                    d.c.sh = nsh;
                    d.c.cnt = n;
                    if (n == ab + 5'h02)
                    begin
                        d.c.op = 2'(nsh >> ab);
                        d.c.sub = 2'(nsh >> (ab - 5'h02));
                        d.c.adr = x8 ? nsh[9:0] : {1'b0, nsh[8:0]};
                        if (d.c.op == `SEC_OP_RD)
                        begin
                            d.c.st = D_READ;
                            d.c.rsh = fetch(x8, d.c.adr);
                            d.c.rcnt = db;
                            d.c.dout = 1'b0;
                        end
                        else if (!(d.c.op == `SEC_OP_WR ||
                            (d.c.op == `SEC_OP_CTL && d.c.sub == `SEC_SUB_WRA)))
                        begin
                            d.c.st = D_ARMED;
                        end
                    end
                    else if (n == ab + db + 5'h02)
                    begin
                        d.c.dat = x8 ? {8'h00, nsh[7:0]} : nsh[15:0];
                        d.c.st = D_ARMED;
                    end
                end
            end
            D_ARMED:
            begin
                if (rise && cs_hi)
                begin
                    // clock overrun: the instruction is dropped
                    d.c.st = D_IDLE;
                end
                else if (csfall)
                begin
                    d.c.st = D_IDLE;
                    if (q.c.op == `SEC_OP_CTL && q.c.sub == `SEC_SUB_WEN)
                    begin
                        d.c.wel = 1'b1;
                    end
                    else if (q.c.op == `SEC_OP_CTL &&
                        q.c.sub == `SEC_SUB_LOCK)
                    begin
                        d.c.wel = 1'b0;
                    end
                    else if (q.c.wel)
                    begin
                        d.c.bcnt = 32'(T_WP_CYC);
                        d.c.stat = 1'b1;
                        if (q.c.op == `SEC_OP_CTL)
                        begin
                            for (int i = 0; i < `SEC_WORDS; i++)
                            begin
                                d.mem[i] = (q.c.sub == `SEC_SUB_ERA) ?
                                    `SEC_ERASED : pat;
                            end
                        end
                        else if (!x8)
                        begin
                            d.mem[q.c.adr[8:0]] = val;
                        end
                        else if (q.c.adr[0])
                        begin
                            d.mem[q.c.adr[9:1]][7:0] = val[7:0];
                        end
                        else
                        begin
                            d.mem[q.c.adr[9:1]][15:8] = val[15:8];
                        end
                    end
                end
            end
            D_READ:
            begin
                if (!cs_hi)
                begin
                    d.c.st = D_IDLE;
                end
                else if (rise)
                begin
                    if (q.c.rcnt == 5'h00)
                    begin
                        d.c.adr = an;
                        d.c.rsh = fetch(x8, an);
                        d.c.rcnt = db;
                    end
                    d.c.dout = d.c.rsh[15];
                    d.c.rsh = {d.c.rsh[14:0], 1'b0};
                    d.c.rcnt = d.c.rcnt - 5'h01;
                end
            end
            default:
            begin
                d.c.st = D_IDLE;
            end
        endcase
        d.c.rdy = (q.c.bcnt == 32'h0);
        if (cs_hi && q.c.stat)
        begin
            d.c.dout = (q.c.bcnt == 32'h0);
        end
        d.c.oe_n = ~(cs_hi & (q.c.stat | (q.c.st == D_READ)));
    end

    // the array itself is not touched by reset
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            q.c <= '0;
            q.c.oe_n <= 1'b1;
            q.c.rdy <= 1'b1;
        end
        else if (CE)
        begin
            q <= d;
        end
    end

    assign LINK.dout = q.c.dout;
    assign LINK.dout_oe_n = q.c.oe_n;
    assign READY = q.c.rdy;
    assign WRITE_ENABLED = q.c.wel;
endmodule : sec_dev
`default_nettype wire

// ### core/sec_host.sv
// host end: read FIFO and the serial link master
`include "sec_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module sec_fifo #(
    parameter int W = 16,
    parameter int DEPTH = `SEC_FIFO_DEPTH
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] n;
    } sec_fst_t;
    sec_fst_t q;
    sec_fst_t d;
    logic push;
    logic pop;

    always_comb
    begin
        d = q;
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        if (push)
        begin
            d.mem[q.wp] = in_data;
            d.wp = q.wp + 1'b1;
        end
        if (pop)
        begin
            d.rp = q.rp + 1'b1;
        end
        d.n = q.n + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            q.wp <= '0;
            q.rp <= '0;
            q.n <= '0;
        end
        else if (CE)
        begin
            q <= d;
        end
    end

    assign in_ready = (q.n != (AW+1)'(DEPTH));
    assign out_valid = (q.n != '0);
    assign out_data = q.mem[q.rp];
endmodule : sec_fifo

module sec_host #(
    parameter int HALF = `SEC_SK_HALF,
    parameter int T_CS_CYC = `SEC_T_CS_CYC
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic WIDTH_SELECT,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire sec_pkg::sec_cmd_t CMD_KIND,
    input wire logic [9:0] CMD_ADDR,
    input wire logic [15:0] CMD_DATA,
    input wire logic [9:0] CMD_WORDS,
    output logic RD_VALID,
    input wire logic RD_READY,
    output logic [15:0] RD_DATA,
    output logic BUSY,
    sec_if.host LINK
);
    import sec_pkg::*;

    typedef struct packed {
        sec_hst_t st;
        logic [7:0] tc;
        logic sk;
        logic cs;
        logic di;
        logic [28:0] fr;
        logic [4:0] nb;
        logic [4:0] rc;
        logic [4:0] db;
        logic rd;
        logic prog;
        logic first;
        logic pv;
        logic rdy;
        logic busy;
        logic [9:0] nw;
        logic [15:0] rw;
        logic [15:0] pd;
        logic [1:0] do_s;
    } sec_hstate_t;
    sec_hstate_t q;
    sec_hstate_t d;
    logic tick;
    logic x8;
    logic ctl;
    logic hd;
    logic [1:0] op;
    logic [1:0] sub;
    logic [15:0] nrw;
    logic in_ready;

    always_comb
    begin
        d = q;
        tick = (q.tc == 8'(HALF - 1));
        x8 = ~WIDTH_SELECT;
        ctl = CMD_KIND inside {C_ERASE_WHOLE_ARRAY, C_WRITE_WHOLE_ARRAY,
            C_WRITE_ENABLE, C_PROGRAM_LOCK};
        hd = CMD_KIND inside {C_WRITE, C_WRITE_WHOLE_ARRAY};
        case (CMD_KIND)
            C_WRITE: op = `SEC_OP_WR;
            C_READ: op = `SEC_OP_RD;
            C_ERASE: op = `SEC_OP_ER;
            default: op = `SEC_OP_CTL;
        endcase
        case (CMD_KIND)
            C_ERASE_WHOLE_ARRAY: sub = `SEC_SUB_ERA;
            C_WRITE_WHOLE_ARRAY: sub = `SEC_SUB_WRA;
            C_WRITE_ENABLE: sub = `SEC_SUB_WEN;
            default: sub = `SEC_SUB_LOCK;
        endcase
        nrw = {q.rw[14:0], q.do_s[1]};
        d.do_s = {q.do_s[0], LINK.dout_pin};
        d.tc = q.tc + 8'h01;
        if (q.pv && in_ready)
        begin
            d.pv = 1'b0;
        end
        case (q.st)
            H_IDLE:
            begin
                d.tc = 8'h00;
                if (CMD_VALID && q.rdy)
                begin
                    d.fr = x8 ? {1'b1, op, (ctl ? {sub, 9'h000} :
                        {1'b0, CMD_ADDR}), CMD_DATA[7:0], 7'h00} :
                        {1'b1, op, (ctl ? {sub, 8'h00} :
                        {1'b0, CMD_ADDR[8:0]}), CMD_DATA};
                    d.db = x8 ? `SEC_DB8 : `SEC_DB16;
                    d.nb = `SEC_HDR + (x8 ? `SEC_AB8 : `SEC_AB16) +
                        (hd ? d.db : 5'h00);
                    d.di = 1'b1;
                    d.cs = 1'b1;
                    d.rd = (CMD_KIND == C_READ);
                    d.prog = !(CMD_KIND inside {C_READ, C_WRITE_ENABLE,
                        C_PROGRAM_LOCK});
                    d.nw = CMD_WORDS;
                    d.first = 1'b1;
                    d.rc = 5'h00;
                    d.rdy = 1'b0;
                    d.busy = 1'b1;
                    d.st = H_LO;
                end
            end
            H_LO:
            begin
                if (tick)
                begin
                    d.sk = 1'b1;
                    d.tc = 8'h00;
                    d.st = H_HI;
                end
            end
            H_HI:
            begin
                if (tick)
                begin
                    d.sk = 1'b0;
                    d.tc = 8'h00;
                    d.fr = {q.fr[27:0], 1'b0};
                    d.di = q.fr[27];
                    d.nb = q.nb - 5'h01;
                    if (q.nb == 5'h01)
                    begin
                        d.cs = q.rd;
                        d.st = q.rd ? H_RLO : H_END;
                    end
                    else
                    begin
                        d.st = H_LO;
                    end
                end
            end
            H_RLO:
            begin
                // a word waiting for FIFO room holds the serial clock
                if (tick && !q.pv)
                begin
                    d.tc = 8'h00;
                    d.sk = 1'b1;
                    d.st = H_RHI;
                    d.first = 1'b0;
                    if (!q.first)
                    begin
                        d.rw = nrw;
                        d.rc = q.rc + 5'h01;
                        if (d.rc == q.db)
                        begin
                            d.pv = 1'b1;
                            d.pd = x8 ? {8'h00, nrw[7:0]} : nrw;
                            d.rc = 5'h00;
                            d.nw = q.nw - 10'h001;
                            if (q.nw == 10'h001)
                            begin
                                d.sk = 1'b0;
                                d.cs = 1'b0;
                                d.st = H_END;
                            end
                        end
                    end
                end
            end
            H_RHI:
            begin
                if (tick)
                begin
                    d.sk = 1'b0;
                    d.tc = 8'h00;
                    d.st = H_RLO;
                end
            end
            H_END:
            begin
                if (q.tc == 8'(T_CS_CYC - 1))
                begin
                    d.tc = 8'h00;
                    if (q.prog)
                    begin
                        d.cs = 1'b1;
                        d.prog = 1'b0;
                        d.st = H_POLL;
                    end
                    else
                    begin
                        d.rdy = 1'b1;
                        d.busy = 1'b0;
                        d.st = H_IDLE;
                    end
                end
            end
            H_POLL:
            begin
                if (q.tc >= `SEC_SETTLE && q.do_s[1])
                begin
                    d.cs = 1'b0;
                    d.tc = 8'h00;
                    d.st = H_END;
                end
            end
            default:
            begin
                d.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            q <= '0;
            q.rdy <= 1'b1;
        end
        else if (CE)
        begin
            q <= d;
        end
    end

    sec_fifo #(.W(16), .DEPTH(`SEC_FIFO_DEPTH)) u_fifo (
        .CLK(CLK),
        .RESETN(RESETN),
        .CE(CE),
        .in_valid(q.pv),
        .in_ready(in_ready),
        .in_data(q.pd),
        .out_valid(RD_VALID),
        .out_ready(RD_READY),
        .out_data(RD_DATA)
    );

    assign LINK.cs = q.cs;
    assign LINK.sk = q.sk;
    assign LINK.di = q.di;
    assign CMD_READY = q.rdy;
    assign BUSY = q.busy;
endmodule : sec_host
`default_nettype wire

// ### verification/sec_link_chk.sv
// assertions on the serial link between the host and EEPROM ends
`timescale 1ns/10ps
`default_nettype none
module sec_link_chk #(
    parameter int T_WP_CYC = 200
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic cs,
    input wire logic sk,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic dout_pin,
    input wire logic READY,
    input wire logic WRITE_ENABLED
);
    int busy_cnt;
    // counts the cycles of one self-timed cycle
    always_ff @(posedge CLK)
    begin
        if (!RESETN || READY)
        begin
            busy_cnt <= 0;
        end
        else
        begin
            busy_cnt <= busy_cnt + 1;
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    property p_idle_release;
        (!cs) [*8] |-> dout_oe_n;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("data out driven with select low");
    property p_reset_out;
        $rose(RESETN) |-> READY && dout_oe_n;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("not in standby after reset");
    property p_reset_lock;
        $rose(RESETN) |-> !WRITE_ENABLED;
    endproperty
    a_reset_lock: assert property (p_reset_lock)
        else $error("write enable latch set after reset");
    property p_busy_low;
        (cs && !READY) [*6] |-> dout_oe_n || !dout;
    endproperty
    a_busy_low: assert property (p_busy_low)
        else $error("busy status not shown as 0");
    property p_ready_high;
        $rose(READY) && cs |-> ##[1:6] dout_pin;
    endproperty
    a_ready_high: assert property (p_ready_high)
        else $error("ready status not shown as 1");
    property p_start_on_fall;
        $fell(READY) |-> !cs && !sk && dout_oe_n;
    endproperty
    a_start_on_fall: assert property (p_start_on_fall)
        else $error("self-timed cycle started with select high");
    property p_start_needs_we;
        $fell(READY) |-> WRITE_ENABLED;
    endproperty
    a_start_needs_we: assert property (p_start_needs_we)
        else $error("programming started with latch clear");
    property p_busy_len;
        $rose(READY) |-> busy_cnt >= T_WP_CYC - 2 && busy_cnt <= T_WP_CYC + 2;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("self-timed cycle length wrong");
    property p_we_on_fall;
        $changed(WRITE_ENABLED) |-> !cs;
    endproperty
    a_we_on_fall: assert property (p_we_on_fall)
        else $error("latch changed with select high");
endmodule : sec_link_chk
`default_nettype wire

// ### verification/serial_eeprom_command_engine_tb.sv
// self-checking bench: host and EEPROM ends joined over the serial link
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_command_engine_tb;
    import sec_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic ws = 1'b1;
    logic cmd_valid = 1'b0;
    sec_cmd_t cmd_kind = C_READ;
    logic [9:0] cmd_addr = 10'h000;
    logic [15:0] cmd_data = 16'h0000;
    logic [9:0] cmd_words = 10'h001;
    logic rd_ready = 1'b0;
    logic cmd_ready, rd_valid, busy, ready, we, saw_busy;
    logic [15:0] rd_data;
    logic [15:0] mem [512];
    int n_errors = 0;
    int checked = 0;
    int i;
    sec_if link();
    sec_dev #(.T_WP_CYC(200)) sec_dev_inst (.CLK(clk), .RESETN(resetn),
        .CE(ce), .WIDTH_SELECT(ws), .READY(ready), .WRITE_ENABLED(we),
        .LINK(link.dev));
    sec_host #(.HALF(16), .T_CS_CYC(40)) sec_host_inst (.CLK(clk),
        .RESETN(resetn), .CE(ce), .WIDTH_SELECT(ws),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_KIND(cmd_kind),
        .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .CMD_WORDS(cmd_words),
        .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data),
        .BUSY(busy), .LINK(link.host));
    sec_link_chk #(.T_WP_CYC(200)) sec_link_chk_inst (.CLK(clk),
        .RESETN(resetn), .cs(link.cs), .sk(link.sk), .dout(link.dout),
        .dout_oe_n(link.dout_oe_n), .dout_pin(link.dout_pin),
        .READY(ready), .WRITE_ENABLED(we));
    always #2.5 clk = ~clk;
    always @(negedge clk)
        if (ready === 1'b0)
            saw_busy = 1'b1;
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : chk
    task automatic hang(input string what);
        $display("mismatch %s expected done seen timeout", what);
        n_errors++;
        give_verdict();
    endtask : hang
    task automatic issue(input sec_cmd_t k, input logic [9:0] a,
        input logic [15:0] d, input logic [9:0] n);
        int j;
        @(posedge clk);
        saw_busy = 1'b0;
        cmd_kind <= k;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_words <= n;
        cmd_valid <= 1'b1;
        for (j = 0; j < 100; j++)
        begin
            @(posedge clk);
            if (cmd_ready === 1'b1)
                break;
        end
        cmd_valid <= 1'b0;
        if (j == 100)
            hang("command take");
    endtask : issue
    task automatic wait_idle();
        int j;
        for (j = 0; j < 40000; j++)
        begin
            @(negedge clk);
            if (busy === 1'b0)
                break;
        end
        if (j == 40000)
            hang("busy");
    endtask : wait_idle
    task automatic op(input sec_cmd_t k, input logic [9:0] a,
        input logic [15:0] d, input logic exp);
        issue(k, a, d, 10'h001);
        wait_idle();
        chk("self-timed start", {15'h0, exp}, {15'h0, saw_busy});
    endtask : op
    task automatic fill(input logic [15:0] v);
        foreach (mem[k])
            mem[k] = v;
    endtask : fill
    // word mode compares whole words, byte mode the low byte only
    task automatic rd(input logic [9:0] a, input int n, input bit stall);
        int j;
        int got;
        logic [9:0] b;
        logic [15:0] w;
        @(posedge clk);
        rd_ready <= !stall;
        issue(C_READ, a, 16'h0000, n[9:0]);
        if (stall)
        begin
            repeat (11000) @(posedge clk);
            chk("busy with fifo full", 16'h0001, {15'h0, busy});
            rd_ready <= 1'b1;
        end
        got = 0;
        for (j = 0; j < 40000 && got < n; j++)
        begin
            @(negedge clk);
            if (rd_valid === 1'b1 && rd_ready === 1'b1)
            begin
                b = a + got[9:0];
                w = ws ? mem[b[8:0]] : mem[b[9:1]];
                if (ws)
                    chk("rd_data", w, rd_data);
                else
                    chk("rd_data", {8'h00, b[0] ? w[7:0] : w[15:8]},
                        {8'h00, rd_data[7:0]});
                got++;
            end
        end
        if (got < n)
            hang("read");
        wait_idle();
    endtask : rd
    initial
    begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk("latch", 16'h0000, {15'h0, we});
        chk("ready", 16'h0001, {15'h0, ready});
        op(C_WRITE_WHOLE_ARRAY, 10'h000, 16'h0F0F, 1'b0);
        op(C_WRITE_ENABLE, 10'h000, 16'h0000, 1'b0);
        chk("latch", 16'h0001, {15'h0, we});
        op(C_ERASE_WHOLE_ARRAY, 10'h2AA, 16'h0000, 1'b1);
        fill(16'hFFFF);
        rd(10'h064, 2, 1'b0);
        op(C_WRITE_WHOLE_ARRAY, 10'h155, 16'hA55A, 1'b1);
        fill(16'hA55A);
        op(C_WRITE, 10'h000, 16'h1234, 1'b1);
        mem[0] = 16'h1234;
        rd(10'h1FC, 20, 1'b1);
        op(C_ERASE, 10'h000, 16'h0000, 1'b1);
        mem[0] = 16'hFFFF;
        rd(10'h1FF, 2, 1'b0);
        op(C_PROGRAM_LOCK, 10'h000, 16'h0000, 1'b0);
        chk("latch", 16'h0000, {15'h0, we});
        op(C_ERASE_WHOLE_ARRAY, 10'h000, 16'h0000, 1'b0);
        rd(10'h001, 1, 1'b0);
        @(posedge clk);
        ws <= 1'b0;
        repeat (20) @(posedge clk);
        op(C_WRITE_ENABLE, 10'h000, 16'h0000, 1'b0);
        op(C_WRITE_WHOLE_ARRAY, 10'h000, 16'h00C3, 1'b1);
        fill(16'hC3C3);
        op(C_WRITE, 10'h005, 16'h0096, 1'b1);
        mem[2] = 16'hC396;
        rd(10'h004, 3, 1'b0);
        issue(C_WRITE_WHOLE_ARRAY, 10'h000, 16'h0011, 10'h001);
        for (i = 0; i < 5000 && ready !== 1'b0; i++)
            @(negedge clk);
        chk("ready before reset", 16'h0000, {15'h0, ready});
        // clock enable low must hold the running self-timed cycle
        @(posedge clk);
        ce <= 1'b0;
        repeat (400) @(posedge clk);
        chk("ready frozen", 16'h0000, {15'h0, ready});
        ce <= 1'b1;
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk("ready", 16'h0001, {15'h0, ready});
        chk("latch", 16'h0000, {15'h0, we});
        give_verdict();
    end
endmodule : serial_eeprom_command_engine_tb
`default_nettype wire
